// *** watchdog_pkg.sv ***
// Shared constants for the watchdog control register block
package watchdog_pkg;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;
  localparam int SEL_W    = 4;
  localparam int WORD_LSB = 2;
  localparam logic [1:0] CONTROL_WORD = 2'h0;
  localparam logic [1:0] STATUS_WORD  = 2'h1;
  // Control word layout
  localparam int ENABLE_BIT  = 15;
  localparam int SHADOW_HI   = 6;
  localparam int SHADOW_LO   = 2;
  localparam int WINDOW_BIT  = 1;
  localparam int CLEAR_BIT   = 0;
  localparam int ENABLE_LANE = 1;
  localparam int CTRL_LANE   = 0;
  // Status word layout
  localparam int SEEN_BIT    = 31;
  localparam int SEEN_LANE   = 3;
  localparam int PS_W        = 5;
  localparam int COUNT_W     = 21;
  localparam logic [PS_W-1:0] PS_MAX = 5'h14;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic WINDOW_RESET = 1'b0;
  // Timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int TICK_TIME_NS    = 1000000;
  localparam int TICK_CYCLES_DEF = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINDOW_SHIFT    = 2;
endpackage

// *** watchdog_counter.sv ***
// Watchdog count with postscaled timeout and window check
`timescale 1ns/1ns
module watchdog_counter
  import watchdog_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               run_i,
  input  wire logic               window_i,
  input  wire logic               clear_i,
  input  wire logic [PS_W-1:0]    postscaler_i,
  output logic      [COUNT_W-1:0] count_o,
  output logic                    expired_o
);
  logic [31:0]        tick_cnt;
  logic [31:0]        next_tick_cnt;
  logic               tick;
  logic [PS_W-1:0]    ps;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic [COUNT_W-1:0] limit;
  logic [COUNT_W-1:0] quarter;
  logic [COUNT_W-1:0] open_at;
  logic               expired;
  logic               next_expired;

  always_comb begin
    // Settings above the widest count saturate instead of wrapping
    ps = (postscaler_i > PS_MAX) ? PS_MAX : postscaler_i;
    limit = COUNT_W'(1) << ps;
    quarter = limit >> WINDOW_SHIFT;
    if (quarter == '0) begin
      quarter = COUNT_W'(1);
    end
    open_at = limit - quarter;
    tick = (tick_cnt == 32'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? '0 : tick_cnt + 32'h1;
    next_count = count;
    next_expired = 1'b0;
    if (!run_i) begin
      next_tick_cnt = '0;
      next_count = '0;
    end else if (clear_i) begin
      next_tick_cnt = '0;
      next_count = '0;
      // A clear before the window opens is treated as a fault
      if (window_i && (count < open_at)) begin
        next_expired = 1'b1;
      end
    end else if (tick) begin
      if (count >= limit - COUNT_W'(1)) begin
        next_count = '0;
        next_expired = 1'b1;
      end else begin
        next_count = count + COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
      count <= '0;
      expired <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      count <= next_count;
      expired <= next_expired;
    end
  end

  assign count_o = count;
  assign expired_o = expired;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  stopped_idle_a: assert property (!run_i |=> count_o == '0 && !expired_o)
    else $error("Stopped watchdog kept counting");
  clear_zero_a: assert property (run_i && clear_i |=> count_o == '0)
    else $error("Count clear did not zero the count");
  early_clear_a: assert property (
    run_i && clear_i && window_i && count < open_at |=> expired_o)
    else $error("Early clear in window mode not flagged");
  expire_pulse_a: assert property (expired_o |=> !expired_o)
    else $error("Expiry lasted more than one cycle");
  expiry_cov: cover property (run_i && tick && count == limit - COUNT_W'(1));
endmodule // watchdog_counter

// *** watchdog_control_register.sv ***
// Watchdog control register with classic Wishbone slave and count
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ns
module watchdog_control_register
  import watchdog_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  input  wire logic [SEL_W-1:0]  wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              config_enable_i,
  input  wire logic [PS_W-1:0]   config_postscaler_i,
  output logic                   running_o,
  output logic                   window_mode_o,
  output logic                   count_clear_o,
  output logic                   expired_o
);
  logic               ack;
  logic               next_ack;
  logic [DATA_W-1:0]  rdata;
  logic [DATA_W-1:0]  next_rdata;
  logic               sw_enable;
  logic               next_sw_enable;
  logic               window_mode;
  logic               next_window_mode;
  logic [PS_W-1:0]    postscaler_shadow;
  logic [PS_W-1:0]    next_postscaler_shadow;
  logic               count_clear;
  logic               next_count_clear;
  logic               seen;
  logic               next_seen;
  logic               req;
  logic               hit_ctrl;
  logic               hit_status;
  logic               wr_ctrl;
  logic               wr_status;
  logic               running;
  logic               expired;
  logic [COUNT_W-1:0] count;
  logic [DATA_W-1:0]  ctrl_word;
  logic [DATA_W-1:0]  status_word;

  // Bus decode and answer
  always_comb begin
    req = wb_cyc_i && wb_stb_i;
    hit_ctrl = (wb_adr_i[ADDR_W-1:WORD_LSB] == CONTROL_WORD);
    hit_status = (wb_adr_i[ADDR_W-1:WORD_LSB] == STATUS_WORD);
    // One wait state; writes land on the edge that sees ack
    next_ack = req && !ack;
    wr_ctrl = req && ack && wb_we_i && hit_ctrl;
    wr_status = req && ack && wb_we_i && hit_status;
  end

  assign running = config_enable_i || sw_enable;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[ENABLE_BIT] = running;
    ctrl_word[SHADOW_HI:SHADOW_LO] = postscaler_shadow;
    ctrl_word[WINDOW_BIT] = window_mode;
    ctrl_word[CLEAR_BIT] = 1'b0;
    status_word = '0;
    status_word[COUNT_W-1:0] = count;
    status_word[SEEN_BIT] = seen;
  end

  // read mux, unused bits stay zero
  always_comb begin
    next_rdata = rdata;
    if (req && !ack) begin
      if (hit_ctrl) begin
        next_rdata = ctrl_word;
      end else if (hit_status) begin
        next_rdata = status_word;
      end else begin
        next_rdata = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= '0;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Control state
  always_comb begin
    next_sw_enable = sw_enable;
    next_window_mode = window_mode;
    next_count_clear = 1'b0;
    next_seen = seen;
    // software enable, cleared by any write to the enable lane while configuration enabled
    if (wr_ctrl && wb_sel_i[ENABLE_LANE]) begin
      if (wb_dat_i[ENABLE_BIT]) begin
        next_sw_enable = !config_enable_i;
      end else begin
        next_sw_enable = 1'b0;
      end
    end
    if (wr_ctrl && wb_sel_i[CTRL_LANE]) begin
      next_window_mode = wb_dat_i[WINDOW_BIT];
    end
    // only a one clears the count
    if (wr_ctrl && wb_sel_i[CTRL_LANE] && wb_dat_i[CLEAR_BIT]) begin
      next_count_clear = 1'b1;
    end
    if (wr_status && wb_sel_i[SEEN_LANE] && wb_dat_i[SEEN_BIT]) begin
      next_seen = 1'b0;
    end
    // Expiry in the clearing cycle is kept
    if (expired) begin
      next_seen = 1'b1;
    end
  end

  // shadow caught on every reset cycle
  always_comb begin
    next_postscaler_shadow = rst_i ? config_postscaler_i : postscaler_shadow;
  end

  always_ff @(posedge clk_i) begin
    postscaler_shadow <= next_postscaler_shadow;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_enable <= ENABLE_RESET;
      window_mode <= WINDOW_RESET;
      count_clear <= 1'b0;
      seen <= 1'b0;
    end else begin
      sw_enable <= next_sw_enable;
      window_mode <= next_window_mode;
      count_clear <= next_count_clear;
      seen <= next_seen;
    end
  end

  watchdog_counter #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_counter (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .run_i        (running),
    .window_i     (window_mode),
    .clear_i      (count_clear),
    .postscaler_i (postscaler_shadow),
    .count_o      (count),
    .expired_o    (expired)
  );

  assign wb_dat_o = rdata;
  assign wb_ack_o = ack;
  assign running_o = running;
  assign window_mode_o = window_mode;
  assign count_clear_o = count_clear;
  assign expired_o = expired;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Bus answer: one wait state, one-cycle ack
  ack_single_a: assert property (
    wb_ack_o
    |=> !wb_ack_o)
    else $error("Ack held longer than one cycle");
  ack_answer_a: assert property (
    req && !ack
    |=> wb_ack_o)
    else $error("Taken request not answered next cycle");
  ack_cause_a: assert property (
    wb_ack_o
    |-> $past(req))
    else $error("Ack without a request");
  rdata_hold_a: assert property (
    !(req && !ack)
    |=> $stable(wb_dat_o))
    else $error("Read data changed without a request");

  enable_start_a: assert property (
    wr_ctrl && wb_sel_i[ENABLE_LANE] && wb_dat_i[ENABLE_BIT]
    |=> running_o)
    else $error("Enable write did not start the watchdog");
  enable_stop_a: assert property (
    wr_ctrl && wb_sel_i[ENABLE_LANE] && !wb_dat_i[ENABLE_BIT] && !config_enable_i
    |=> !running_o)
    else $error("Disable write did not stop software enable");
  enable_keep_a: assert property (
    !(wr_ctrl && wb_sel_i[ENABLE_LANE])
    |=> $stable(sw_enable))
    else $error("Software enable changed without a write");
  config_block_a: assert property (
    wr_ctrl && wb_sel_i[ENABLE_LANE] && config_enable_i
    |=> !sw_enable)
    else $error("Software enable set under configuration enable");

  enable_read_a: assert property (
    req && !ack && hit_ctrl
    |=> wb_dat_o[ENABLE_BIT] == $past(running))
    else $error("Enable bit read back wrong");

  shadow_load_a: assert property (
    $fell(rst_i)
    |-> postscaler_shadow == $past(config_postscaler_i))
    else $error("Shadow not loaded at reset");
  shadow_read_a: assert property (
    req && !ack && hit_ctrl
    |=> wb_dat_o[SHADOW_HI:SHADOW_LO] == postscaler_shadow)
    else $error("Shadow field read back wrong");
  shadow_hold_a: assert property (
    !rst_i
    |=> $stable(postscaler_shadow))
    else $error("Shadow changed outside reset");

  window_write_a: assert property (
    wr_ctrl && wb_sel_i[CTRL_LANE]
    |=> window_mode_o == $past(wb_dat_i[WINDOW_BIT]))
    else $error("Window bit not written");
  window_keep_a: assert property (
    !(wr_ctrl && wb_sel_i[CTRL_LANE])
    |=> $stable(window_mode_o))
    else $error("Window bit changed without a write");
  window_reset_a: assert property (
    $fell(rst_i)
    |-> !window_mode_o)
    else $error("Window bit not zero after reset");

  // count clear only on a written one
  clear_fire_a: assert property (
    wr_ctrl && wb_sel_i[CTRL_LANE] && wb_dat_i[CLEAR_BIT]
    |=> count_clear_o ##1 count == '0)
    else $error("Count clear write had no effect");
  clear_cause_a: assert property (
    count_clear_o
    |-> $past(wr_ctrl && wb_sel_i[CTRL_LANE] && wb_dat_i[CLEAR_BIT]))
    else $error("Count clear without a written one");
  zero_clear_a: assert property (
    wr_ctrl && wb_sel_i[CTRL_LANE] && !wb_dat_i[CLEAR_BIT]
    |=> !count_clear_o)
    else $error("Written zero cleared the count");

  unused_zero_a: assert property (
    wb_ack_o && hit_ctrl
    |-> wb_dat_o[DATA_W-1:ENABLE_BIT+1] == '0 && wb_dat_o[ENABLE_BIT-1:SHADOW_HI+1] == '0)
    else $error("Unimplemented control bits not zero");
  status_unused_a: assert property (
    wb_ack_o && hit_status
    |-> wb_dat_o[SEEN_BIT-1:COUNT_W] == '0)
    else $error("Unimplemented status bits not zero");
  unmapped_zero_a: assert property (
    wb_ack_o && !hit_ctrl && !hit_status
    |-> wb_dat_o == '0)
    else $error("Unmapped word not read as zero");
  unmapped_keep_a: assert property (
    req && ack && wb_we_i && !hit_ctrl && !hit_status
    |=> $stable(sw_enable) && $stable(window_mode) && !count_clear_o)
    else $error("Unmapped write changed state");

  clear_self_a: assert property (
    count_clear_o
    |=> !count_clear_o)
    else $error("Clear bit did not return to zero");
  clear_read_a: assert property (
    wb_ack_o && hit_ctrl
    |-> !wb_dat_o[CLEAR_BIT])
    else $error("Clear bit read back as one");

  // Status word and sticky timeout flag
  status_read_a: assert property (
    req && !ack && hit_status
    |=> wb_dat_o[COUNT_W-1:0] == $past(count))
    else $error("Count read back wrong");
  seen_set_a: assert property (
    expired
    |=> seen)
    else $error("Timeout not recorded");
  seen_keep_a: assert property (
    seen && !expired && !(wr_status && wb_sel_i[SEEN_LANE] && wb_dat_i[SEEN_BIT])
    |=> seen)
    else $error("Timeout flag lost without a clear");

  enable_cov: cover property (wr_ctrl && wb_dat_i[ENABLE_BIT] ##1 running_o);
  clear_cov: cover property (count_clear_o);
  window_cov: cover property (window_mode_o && count_clear_o);
  expire_cov: cover property (expired_o ##[1:8] wb_ack_o);
endmodule // watchdog_control_register

// *** tb.sv ***
// Self-checking bench for the watchdog control register
`timescale 1ns/1ns
module tb;
  import watchdog_pkg::*;
  logic              clk_i;
  logic              rst_i;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [DATA_W-1:0] wb_dat_i;
  logic [SEL_W-1:0]  wb_sel_i;
  logic              wb_we_i;
  logic              wb_cyc_i;
  logic              wb_stb_i;
  logic [DATA_W-1:0] wb_dat_o;
  logic              wb_ack_o;
  logic              config_enable_i;
  logic [PS_W-1:0]   config_postscaler_i;
  logic              running_o;
  logic              window_mode_o;
  logic              count_clear_o;
  logic              expired_o;
  logic [DATA_W-1:0] rd;
  logic              run_s, win_s, clr_s;
  localparam int     TB_TICK = 4;
  int                fail_count;
  int                compares;

  // Short tick keeps the counter busy in a short run
  watchdog_control_register #(.TICK_CYCLES(TB_TICK)) i_watchdog_control_register (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .config_enable_i(config_enable_i),
    .config_postscaler_i(config_postscaler_i), .running_o(running_o),
    .window_mode_o(window_mode_o), .count_clear_o(count_clear_o), .expired_o(expired_o));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
                     input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [DATA_W-1:0] ctrl(input logic run, input logic [PS_W-1:0] ps,
                                             input logic win);
    ctrl = {16'h0000, run, 8'h00, ps, win, 1'b0};
  endfunction

  // One classic cycle; outputs snapshotted just after the ack edge
  task automatic bus(input logic we, input logic [ADDR_W-1:0] adr,
                     input logic [DATA_W-1:0] dat, input logic [SEL_W-1:0] sel);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      chk(32'h0, 32'h1, "ack timeout");
      results();
    end else begin
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      #1;
      run_s = running_o;
      win_s = window_mode_o;
      clr_s = count_clear_o;
      @(posedge clk_i);
    end
  endtask

  task automatic do_reset(input logic en, input logic [PS_W-1:0] ps);
    rst_i <= 1'b1;
    config_enable_i <= en;
    config_postscaler_i <= ps;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic test_reset();
    logic [PS_W-1:0] ps [3] = '{5'h00, 5'h1f, 5'h0a};
    foreach (ps[i]) begin
      do_reset(1'b0, ps[i]);
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      chk(rd, ctrl(1'b0, ps[i], 1'b0), "reset value");
      chk({31'h0, win_s}, 32'h0, "window after reset");
    end
    $display("test reset done");
  endtask

  task automatic test_enable();
    bus(1'b1, 4'h0, 32'h00008000, 4'h2);
    chk({31'h0, run_s}, 32'h1, "sw enable");
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk(rd, ctrl(1'b1, 5'h0a, 1'b0), "enable readback");
    bus(1'b1, 4'h0, 32'h0, 4'hf);
    chk({31'h0, run_s}, 32'h0, "sw disable");
    $display("test enable done");
  endtask

  task automatic test_bits();
    bus(1'b1, 4'h0, 32'hffffffff, 4'hf);
    chk({30'h0, win_s, clr_s}, 32'h3, "window and clear");
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk(rd, ctrl(1'b1, 5'h0a, 1'b1), "unused bits zero");
    chk({31'h0, clr_s}, 32'h0, "clear pulse ended");
    bus(1'b1, 4'h0, 32'h00000001, 4'h1);
    chk({30'h0, win_s, clr_s}, 32'h1, "clear drops window");
    bus(1'b1, 4'h0, 32'h0, 4'hf);
    chk({31'h0, clr_s}, 32'h0, "zero clear ignored");
    bus(1'b1, 4'h8, 32'hffffffff, 4'hf);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk(rd, 32'h0, "unmapped word");
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk(rd, ctrl(1'b0, 5'h0a, 1'b0), "control after all");
    $display("test bits done");
  endtask

  task automatic test_config();
    do_reset(1'b1, 5'h03);
    bus(1'b1, 4'h0, 32'h0, 4'hf);
    chk({31'h0, run_s}, 32'h1, "config keeps running");
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk(rd, ctrl(1'b1, 5'h03, 1'b0), "config enable reads");
    $display("test config done");
  endtask

  // Expiry time after a clear, sticky timeout flag, early clear in window mode
  task automatic test_status();
    int n;
    n = 0;
    bus(1'b1, 4'h0, 32'h00000001, 4'h1);
    do begin
      @(posedge clk_i);
      n++;
    end while (expired_o !== 1'b1 && n < 100);
    // Postscaler 3 from the configuration reset: 8 ticks to timeout
    chk(n, 32'((1 << 3) * TB_TICK + 1), "expiry time");
    if (expired_o !== 1'b1) begin
      results();
    end else begin
      bus(1'b0, 4'h4, 32'h0, 4'hf);
      chk(rd, 32'h80000000, "timeout seen");
      bus(1'b1, 4'h4, 32'h80000000, 4'h8);
      bus(1'b0, 4'h4, 32'h0, 4'hf);
      chk({31'h0, rd[SEEN_BIT]}, 32'h0, "seen cleared");
      bus(1'b1, 4'h0, 32'h00000003, 4'h1);
      @(posedge clk_i);
      chk({30'h0, win_s, expired_o}, 32'h3, "early clear fault");
      bus(1'b0, 4'h4, 32'h0, 4'hf);
      chk(rd, 32'h80000000, "clear zeroed count");
      $display("test status done");
    end
  endtask

  initial begin
    fail_count = 0;
    compares = 0;
    rst_i = 1'b1;
    wb_adr_i = 4'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    config_enable_i = 1'b0;
    config_postscaler_i = 5'h00;
    @(posedge clk_i);
    test_reset();
    test_enable();
    test_bits();
    test_config();
    test_status();
    results();
  end
endmodule // tb
